// ---- logic/sd_cmd_pkg.sv ----
// Constants, types and decode functions of the card command issuer
//
// Behaviour
// [RULE1] After the prefix command the card reads the next command as application-specific.
// [RULE2] Application commands share the standard frame; only the preceding prefix marks them.
// [RULE3] A prefixed index without application meaning runs as the standard command.
// [RULE4] Host sends prefix then command; both responses must show the application status bit.
// [RULE5] A non-application command after the prefix runs normally and clears the status bit.
// [RULE6] Illegal prefixed commands get the same error handling as standard illegal ones; the issuer refuses reserved indices only in unprefixed requests.
// [RULE7] General data command moves one block; argument bit 0 gives direction.
// [RULE8] General data command needs a selected card, set block length; busy response follows.
// [RULE9] Block count command: argument bits 31..16 zero, count in bits 15..0.
// [RULE10] Single block write takes exactly one block at the set length.
// [RULE11] Multi block write runs until stop command or preset count.
// [RULE12] Identifier programming is accepted once per card only.
// [RULE13] Specific data programming updates only the programmable bits.
// [RULE14] Set-protect marks the group holding the address; busy response.
// [RULE15] Clear-protect clears the group holding the address; busy response.
// [RULE16] Protect query returns group protect bits as data, normal response.
// [RULE17] Erase start records the first erase group address.
// [RULE18] Erase end records the last erase group address.
// [RULE19] Erase command erases the recorded range.
// [RULE20] Reserved command indices are never issued; the issuer blocks them only in requests without the prefix.
// [RULE21] Each command frame is 48 bits: start, direction, index, argument, CRC7, end.
// [RULE22] The application command follows the prefix response with nothing in between.
package sd_cmd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 20_000_000;
  localparam int CARD_CLK_HZ = 5_000_000;
  localparam int HALF_DIV    = CLK_HZ / (2 * CARD_CLK_HZ);
  localparam int BIT_CYC     = 2 * HALF_DIV;
  localparam logic [1:0]  HALF_LAST = 2'(HALF_DIV - 1);
  localparam logic [15:0] NCR_MAX   = 16'h0040;
  localparam logic [15:0] BUSY_MAX  = 16'hFFFF;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [5:0] FRAME_BITS     = 6'h30;
  localparam logic [5:0] RSP_LAST       = 6'h2F;
  localparam int         RSP_ARG_LO     = 8;
  localparam int         RSP_ARG_HI     = 39;
  localparam int         APP_STATUS_BIT = 5;

  // ----------------------------------------------------------------
  // Command indices
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_GO_IDLE      = 6'h00;
  localparam logic [5:0] CMD_SELECT       = 6'h07;
  localparam logic [5:0] CMD_STOP         = 6'h0C;
  localparam logic [5:0] CMD_SET_BLKLEN   = 6'h10;
  localparam logic [5:0] CMD_READ_SINGLE  = 6'h11;
  localparam logic [5:0] CMD_READ_MULTI   = 6'h12;
  localparam logic [5:0] CMD_SET_BLKCNT   = 6'h17;
  localparam logic [5:0] CMD_WRITE_SINGLE = 6'h18;
  localparam logic [5:0] CMD_WRITE_MULTI  = 6'h19;
  localparam logic [5:0] CMD_PROG_ID      = 6'h1A;
  localparam logic [5:0] CMD_PROG_SPEC    = 6'h1B;
  localparam logic [5:0] CMD_SET_WP       = 6'h1C;
  localparam logic [5:0] CMD_CLR_WP       = 6'h1D;
  localparam logic [5:0] CMD_QUERY_WP     = 6'h1E;
  localparam logic [5:0] CMD_ERASE        = 6'h26;
  localparam logic [5:0] CMD_APP_PREFIX   = 6'h37;
  localparam logic [5:0] CMD_GEN_DATA     = 6'h38;

  // ----------------------------------------------------------------
  // Result codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ERR_OK      = 3'h0;
  localparam logic [2:0] ERR_REFUSED = 3'h1;
  localparam logic [2:0] ERR_NO_RSP  = 3'h2;
  localparam logic [2:0] ERR_NO_APP  = 3'h3;
  localparam logic [2:0] ERR_BUSY_TO = 3'h4;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {PH_IDLE, PH_SEND, PH_WAIT, PH_RECV, PH_BUSY} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [1:0]  div;
    logic        sd_clk;
    logic [47:0] shift;
    logic [5:0]  bits;
    logic [15:0] timer;
    logic [5:0]  idx;
    logic [31:0] arg;
    logic        app;
    logic        prefix;
    logic        cmd_out;
    logic        cmd_oe_n;
    logic        ready;
    logic        done;
    logic [2:0]  err;
    logic [31:0] status;
    logic        app_ok;
    logic        selected;
    logic        blklen_set;
    logic        xfer_start;
    logic        xfer_dir;
  } state_t;

  localparam state_t STATE_RESET = '{phase: PH_IDLE, cmd_out: 1'b1, cmd_oe_n: 1'b1, ready: 1'b1, default: '0};

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic is_reserved(input logic [5:0] idx);
    return idx inside {6'h1F, [6'h20:6'h22], 6'h25, 6'h29, [6'h2B:6'h36], [6'h39:6'h3F]};
  endfunction

  function automatic logic needs_busy(input logic [5:0] idx);
    return idx inside {CMD_SELECT, CMD_STOP, CMD_SET_WP, CMD_CLR_WP, CMD_ERASE, CMD_GEN_DATA};
  endfunction

  function automatic logic is_data(input logic [5:0] idx);
    return idx inside {CMD_READ_SINGLE, CMD_READ_MULTI, CMD_WRITE_SINGLE, CMD_WRITE_MULTI,
                       CMD_PROG_ID, CMD_PROG_SPEC, CMD_QUERY_WP, CMD_GEN_DATA};
  endfunction

  function automatic logic is_read(input logic [5:0] idx);
    return idx inside {CMD_READ_SINGLE, CMD_READ_MULTI, CMD_QUERY_WP};
  endfunction

  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
    begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0};
      if (fb)
      begin
        c = c ^ 7'h09;
      end
    end
    return c;
  endfunction

  function automatic logic [47:0] build_frame(input logic [5:0] idx, input logic [31:0] arg);
    return {1'b0, 1'b1, idx, arg, crc7({1'b0, 1'b1, idx, arg}), 1'b1};
  endfunction

endpackage

// ---- logic/sd_cmd_issuer.sv ----
// Host-side command issuer: frames, prefix sequencing, response and busy wait
`timescale 1ns/1ps
`default_nettype none

module sd_cmd_issuer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Command request
  input  wire logic        cmd_valid,
  input  wire logic [5:0]  cmd_index,
  input  wire logic [31:0] cmd_arg,
  input  wire logic        cmd_app,
  input  wire logic [15:0] card_rca,
  output logic             cmd_ready,
  // Command result
  output logic             cmd_done,
  output logic [2:0]       cmd_err,
  output logic [31:0]      card_status,
  output logic             app_accepted,
  output logic             card_selected,
  output logic             xfer_start,
  output logic             xfer_dir,
  // Card link
  output logic             sd_clk,
  output logic             cmd_out,
  output logic             cmd_oe_n,
  input  wire logic        cmd_in,
  input  wire logic        dat0_in
);

  sd_cmd_pkg::state_t st_reg;
  sd_cmd_pkg::state_t st_next;
  logic               half_end;
  logic               drive_en;
  logic               samp_en;
  logic               refused;
  logic [47:0]        full_rsp;

  // ----------------------------------------------------------------
  // Card clock divider: drive on falling, sample on rising edge
  // ----------------------------------------------------------------
  assign half_end = (st_reg.div == sd_cmd_pkg::HALF_LAST);
  assign drive_en = half_end && st_reg.sd_clk;
  assign samp_en  = half_end && !st_reg.sd_clk;
  assign full_rsp = {st_reg.shift[46:0], cmd_in};

  // ----------------------------------------------------------------
  // Request screening
  // ----------------------------------------------------------------
  assign refused = (!cmd_app && sd_cmd_pkg::is_reserved(cmd_index))                                 // see [RULE20]
                || (!cmd_app && cmd_index == sd_cmd_pkg::CMD_SET_BLKCNT && cmd_arg[31:16] != 16'h0000) // see [RULE9]
                || (!cmd_app && cmd_index == sd_cmd_pkg::CMD_GEN_DATA
                    && !(st_reg.selected && st_reg.blklen_set));                                     // see [RULE8]

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next            = st_reg;
    st_next.done       = 1'b0;
    st_next.xfer_start = 1'b0;
    st_next.div        = half_end ? 2'h0 : st_reg.div + 2'h1;
    if (half_end)
    begin
      st_next.sd_clk = ~st_reg.sd_clk;
    end
    case (st_reg.phase)
      sd_cmd_pkg::PH_IDLE:
      begin
        if (cmd_valid)
        begin
          if (refused)
          begin
            st_next.done = 1'b1;
            st_next.err  = sd_cmd_pkg::ERR_REFUSED;
          end
          else
          begin
            st_next.ready  = 1'b0;
            st_next.idx    = cmd_index;
            st_next.arg    = cmd_arg;
            st_next.app    = cmd_app;
            st_next.prefix = cmd_app;
            st_next.bits   = 6'h00;
            st_next.err    = sd_cmd_pkg::ERR_OK;
            st_next.app_ok = 1'b0;
            st_next.phase  = sd_cmd_pkg::PH_SEND;
            // Prefix goes out first when an application command is asked for
            st_next.shift  = cmd_app
                           ? sd_cmd_pkg::build_frame(sd_cmd_pkg::CMD_APP_PREFIX, {card_rca, 16'h0000}) // see [RULE4]
                           : sd_cmd_pkg::build_frame(cmd_index, cmd_arg);                             // see [RULE21]
          end
        end
      end
      sd_cmd_pkg::PH_SEND:
      begin
        if (drive_en)
        begin
          if (st_reg.bits == sd_cmd_pkg::FRAME_BITS)
          begin
            st_next.cmd_oe_n = 1'b1;
            st_next.cmd_out  = 1'b1;
            st_next.timer    = 16'h0000;
            st_next.bits     = 6'h00;
            if (st_reg.idx == sd_cmd_pkg::CMD_GO_IDLE && !st_reg.prefix)
            begin
              st_next.selected   = 1'b0;
              st_next.blklen_set = 1'b0;
              st_next.phase      = sd_cmd_pkg::PH_IDLE;
              st_next.ready      = 1'b1;
              st_next.done       = 1'b1;
            end
            else
            begin
              st_next.phase = sd_cmd_pkg::PH_WAIT;
            end
          end
          else
          begin
            st_next.cmd_out  = st_reg.shift[47];                 // see [RULE21]
            st_next.cmd_oe_n = 1'b0;
            st_next.shift    = {st_reg.shift[46:0], 1'b0};
            st_next.bits     = st_reg.bits + 6'h01;
          end
        end
      end
      sd_cmd_pkg::PH_WAIT:
      begin
        if (samp_en)
        begin
          if (!cmd_in)
          begin
            st_next.phase = sd_cmd_pkg::PH_RECV;
            st_next.bits  = 6'h01;
            st_next.shift = full_rsp;
          end
          else if (st_reg.timer == sd_cmd_pkg::NCR_MAX)
          begin
            st_next.phase = sd_cmd_pkg::PH_IDLE;
            st_next.ready = 1'b1;
            st_next.done  = 1'b1;
            st_next.err   = sd_cmd_pkg::ERR_NO_RSP;
          end
          else
          begin
            st_next.timer = st_reg.timer + 16'h0001;
          end
        end
      end
      sd_cmd_pkg::PH_RECV:
      begin
        if (samp_en)
        begin
          st_next.shift = full_rsp;
          st_next.bits  = st_reg.bits + 6'h01;
          if (st_reg.bits == sd_cmd_pkg::RSP_LAST)
          begin
            st_next.status = full_rsp[sd_cmd_pkg::RSP_ARG_HI:sd_cmd_pkg::RSP_ARG_LO];
            st_next.bits   = 6'h00;
            st_next.timer  = 16'h0000;
            if (st_reg.prefix)
            begin
              if (full_rsp[sd_cmd_pkg::RSP_ARG_LO + sd_cmd_pkg::APP_STATUS_BIT])
              begin
                // Application command goes out straight after the prefix answer
                st_next.prefix = 1'b0;                                            // see [RULE22]
                st_next.shift  = sd_cmd_pkg::build_frame(st_reg.idx, st_reg.arg);
                st_next.phase  = sd_cmd_pkg::PH_SEND;
              end
              else
              begin
                st_next.phase = sd_cmd_pkg::PH_IDLE;                              // see [RULE4]
                st_next.ready = 1'b1;
                st_next.done  = 1'b1;
                st_next.err   = sd_cmd_pkg::ERR_NO_APP;
              end
            end
            else
            begin
              st_next.app_ok = st_reg.app && full_rsp[sd_cmd_pkg::RSP_ARG_LO + sd_cmd_pkg::APP_STATUS_BIT]; // see [RULE4]
              if (!st_reg.app && st_reg.idx == sd_cmd_pkg::CMD_SELECT)
              begin
                st_next.selected = (st_reg.arg[31:16] != 16'h0000);
              end
              if (!st_reg.app && st_reg.idx == sd_cmd_pkg::CMD_SET_BLKLEN)
              begin
                st_next.blklen_set = 1'b1;
              end
              if (sd_cmd_pkg::is_data(st_reg.idx))
              begin
                st_next.xfer_start = 1'b1;
                st_next.xfer_dir   = (st_reg.idx == sd_cmd_pkg::CMD_GEN_DATA)
                                   ? st_reg.arg[0]                              // see [RULE7]
                                   : sd_cmd_pkg::is_read(st_reg.idx);
              end
              if (sd_cmd_pkg::needs_busy(st_reg.idx))
              begin
                st_next.phase = sd_cmd_pkg::PH_BUSY;                            // see [RULE8]
              end
              else
              begin
                st_next.phase = sd_cmd_pkg::PH_IDLE;
                st_next.ready = 1'b1;
                st_next.done  = 1'b1;
              end
            end
          end
        end
      end
      sd_cmd_pkg::PH_BUSY:
      begin
        if (samp_en)
        begin
          if (dat0_in)
          begin
            st_next.phase = sd_cmd_pkg::PH_IDLE;                                // see [RULE8]
            st_next.ready = 1'b1;
            st_next.done  = 1'b1;
          end
          else if (st_reg.timer == sd_cmd_pkg::BUSY_MAX)
          begin
            st_next.phase = sd_cmd_pkg::PH_IDLE;
            st_next.ready = 1'b1;
            st_next.done  = 1'b1;
            st_next.err   = sd_cmd_pkg::ERR_BUSY_TO;
          end
          else
          begin
            st_next.timer = st_reg.timer + 16'h0001;
          end
        end
      end
      default:
      begin
        st_next = sd_cmd_pkg::STATE_RESET;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st_reg <= sd_cmd_pkg::STATE_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmd_ready     = st_reg.ready;
  assign cmd_done      = st_reg.done;
  assign cmd_err       = st_reg.err;
  assign card_status   = st_reg.status;
  assign app_accepted  = st_reg.app_ok;
  assign card_selected = st_reg.selected;
  assign xfer_start    = st_reg.xfer_start;
  assign xfer_dir      = st_reg.xfer_dir;
  assign sd_clk        = st_reg.sd_clk;
  assign cmd_out       = st_reg.cmd_out;
  assign cmd_oe_n      = st_reg.cmd_oe_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int FRAME_CYC = 48 * sd_cmd_pkg::BIT_CYC;
  logic [7:0] low_cnt;

  always_ff @(posedge clock)
  begin
    if (reset || cmd_oe_n)
    begin
      low_cnt <= 8'h00;
    end
    else
    begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence prefix_ok_s;
    st_reg.phase == sd_cmd_pkg::PH_RECV && st_reg.prefix && samp_en
      && st_reg.bits == sd_cmd_pkg::RSP_LAST && full_rsp[13];
  endsequence

  sequence prefix_bad_s;
    st_reg.phase == sd_cmd_pkg::PH_RECV && st_reg.prefix && samp_en
      && st_reg.bits == sd_cmd_pkg::RSP_LAST && !full_rsp[13];
  endsequence

  frame_length_a: assert property ($rose(cmd_oe_n) |-> low_cnt == 8'(FRAME_CYC)) // see [RULE21]
    else $error("command frame not 48 bit times long");
  frame_start_a: assert property ($fell(cmd_oe_n) |-> !cmd_out ##4 cmd_out && !cmd_oe_n) // see [RULE21]
    else $error("frame does not open with start and direction bits");
  app_follows_a: assert property (prefix_ok_s |=> (!cmd_ready throughout ##[0:8] $fell(cmd_oe_n))) // see [RULE22]
    else $error("application command did not follow prefix answer");
  prefix_check_a: assert property (prefix_bad_s |=> cmd_done && cmd_err == sd_cmd_pkg::ERR_NO_APP && cmd_oe_n) // see [RULE4]
    else $error("prefix answer without status bit not reported");
  reserved_block_a: assert property (cmd_valid && cmd_ready && !cmd_app && sd_cmd_pkg::is_reserved(cmd_index)
                                     |=> cmd_done && cmd_err == sd_cmd_pkg::ERR_REFUSED ##1 cmd_oe_n) // see [RULE20]
    else $error("reserved index was not refused");
  blkcnt_form_a: assert property (cmd_valid && cmd_ready && !cmd_app && cmd_index == sd_cmd_pkg::CMD_SET_BLKCNT
                                  && cmd_arg[31:16] != 16'h0000 |=> cmd_err == sd_cmd_pkg::ERR_REFUSED && cmd_ready) // see [RULE9]
    else $error("block count with high bits set was sent");
  gen_gate_a: assert property (cmd_valid && cmd_ready && !cmd_app && cmd_index == sd_cmd_pkg::CMD_GEN_DATA
                               && !(st_reg.selected && st_reg.blklen_set) |=> cmd_done && cmd_err == sd_cmd_pkg::ERR_REFUSED) // see [RULE8]
    else $error("general data command sent without preparation");
  busy_hold_a: assert property (st_reg.phase == sd_cmd_pkg::PH_BUSY && samp_en && !dat0_in
                                && st_reg.timer != sd_cmd_pkg::BUSY_MAX |=> !cmd_done && !cmd_ready) // see [RULE8]
    else $error("busy wait ended while card busy");
  gen_dir_a: assert property (xfer_start && st_reg.idx == sd_cmd_pkg::CMD_GEN_DATA
                              |-> xfer_dir == $past(st_reg.arg[0])) // see [RULE7]
    else $error("general data direction wrong");

endmodule // sd_cmd_issuer

`default_nettype wire

// ---- verification/sd_card_model.sv ----
// Behavioural card answering frames on the command line
`timescale 1ns/1ps
`default_nettype none

module sd_card_model (
  // Card link
  input  wire logic        sd_clk,
  input  wire logic        cmd_out,
  input  wire logic        cmd_oe_n,
  output logic             cmd_in,
  output logic             dat0_in,
  // Scenario controls
  input  wire logic        mute,
  input  wire logic        no_app,
  input  wire logic [15:0] busy_bits,
  output logic [47:0]      last_frame
);
  logic        drv;
  logic        bit_val;
  logic        app_pend;
  logic        cid_used;
  logic [5:0]  idx;
  logic [31:0] stat;
  logic [31:0] erase_lo;
  logic [31:0] erase_hi;
  logic [47:0] rsp;

  // Pulled-up line: the card drives only while the host floats it
  assign cmd_in = !cmd_oe_n ? cmd_out : (drv ? bit_val : 1'b1);

  initial
  begin
    drv = 1'b0;
    bit_val = 1'b1;
    dat0_in = 1'b1;
    app_pend = 1'b0;
    cid_used = 1'b0;
    last_frame = '0;
    forever
    begin
      @(posedge sd_clk);
      if (cmd_oe_n === 1'b0 && cmd_out === 1'b0)
      begin
        last_frame[47] = 1'b0;
        for (int i = 46; i >= 0; i--)
        begin
          @(posedge sd_clk);
          last_frame[i] = cmd_out;
        end
        idx = last_frame[45:40];
        stat = 32'h0000_0000;
        stat[5] = (idx == 6'h37 && !no_app) || (app_pend && idx inside {6'h06, 6'h0d, 6'h16, 6'h29});
        stat[22] = !app_pend && idx inside {6'h1f, 6'h25, [6'h39:6'h3f]};
        stat[19] = idx == 6'h1a && cid_used;
        cid_used = cid_used || idx == 6'h1a;
        app_pend = idx == 6'h37;
        if (idx == 6'h23)
          erase_lo = last_frame[39:8];
        if (idx == 6'h24)
          erase_hi = last_frame[39:8];
        rsp = {2'b00, idx, stat, 7'h7f, 1'b1};
        if (idx != 6'h00 && !mute)
        begin
          repeat (2) @(posedge sd_clk);
          for (int i = 47; i >= 0; i--)
          begin
            @(negedge sd_clk);
            drv = 1'b1;
            bit_val = rsp[i];
          end
          dat0_in = !(idx inside {6'h07, 6'h0c, 6'h1c, 6'h1d, 6'h26, 6'h38});
          @(negedge sd_clk);
          drv = 1'b0;
          // Only busy commands hold data0; others must not miss the next start bit
          if (!dat0_in)
            repeat (busy_bits) @(posedge sd_clk);
          dat0_in = 1'b1;
        end
      end
    end
  end
endmodule // sd_card_model

`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the command issuer against the card model
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct packed {
    logic [2:0]  err;
    logic        app;
    logic        xs;
    logic        dir;
    logic [5:0]  idx;
    logic [31:0] arg;
    logic        cid;
  } note_t;

  logic        clock, reset, cmd_valid, cmd_app, cmd_ready, cmd_done;
  logic        app_accepted, card_selected, xfer_start, xfer_dir, seen_xs, cid_sent;
  logic        sd_clk, cmd_out, cmd_oe_n, cmd_in, dat0_in, mute, no_app;
  logic [5:0]  cmd_index;
  logic [31:0] cmd_arg, card_status;
  logic [15:0] card_rca, busy_bits;
  logic [2:0]  cmd_err;
  logic [47:0] frame;
  note_t       notes[$];
  note_t       n;
  int          checks, miscompares;
  logic [5:0]  rsv[8] = '{6'h1f, 6'h20, 6'h25, 6'h29, 6'h2b, 6'h36, 6'h39, 6'h3f};
  logic [5:0]  normal[13] = '{6'h18, 6'h19, 6'h1a, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h23, 6'h24, 6'h26, 6'h0c, 6'h11};

  sd_cmd_issuer dut (.clock(clock), .reset(reset), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
    .cmd_arg(cmd_arg), .cmd_app(cmd_app), .card_rca(card_rca), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .cmd_err(cmd_err), .card_status(card_status), .app_accepted(app_accepted), .card_selected(card_selected),
    .xfer_start(xfer_start), .xfer_dir(xfer_dir), .sd_clk(sd_clk), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n),
    .cmd_in(cmd_in), .dat0_in(dat0_in));
  sd_card_model card (.sd_clk(sd_clk), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n), .cmd_in(cmd_in),
    .dat0_in(dat0_in), .mute(mute), .no_app(no_app), .busy_bits(busy_bits), .last_frame(frame));

  function automatic logic [6:0] crc(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction

  task automatic fail(input string what);
    miscompares++;
    $display("unexpected at %0t: %s", $time, what);
  endtask

  task automatic cmp_code(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp)
      fail($sformatf("result code %h not %h", got, exp));
  endtask

  task automatic cmp_flag(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp)
      fail($sformatf("%s is %b", what, got));
  endtask

  task automatic cmp_frame(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp)
      fail($sformatf("frame %h not %h", got, exp));
  endtask

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (checks > 0 && miscompares == 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Drive one request at the falling edge and note what must come back
  task automatic issue(input logic [5:0] idx, input logic [31:0] arg, input logic app, input logic [2:0] err);
    note_t m;
    m.err = err;
    m.app = app && err == 3'h0 && idx inside {6'h06, 6'h0d, 6'h16, 6'h29};
    m.xs = err == 3'h0 && idx inside {6'h11, 6'h12, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1e, 6'h38};
    m.dir = idx == 6'h38 ? arg[0] : idx inside {6'h11, 6'h12, 6'h1e};
    // A prefix answered without the status bit leaves the prefix as the last frame
    m.idx = err == 3'h3 ? 6'h37 : idx;
    m.arg = err == 3'h3 ? {card_rca, 16'h0000} : arg;
    m.cid = idx == 6'h1a && cid_sent;
    cid_sent = cid_sent || (idx == 6'h1a && err == 3'h0);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_index = idx;
    cmd_arg = arg;
    cmd_app = app;
    notes.push_back(m);
    @(negedge clock);
    cmd_valid = 1'b0;
    for (int k = 0; k < 20_000 && cmd_done !== 1'b1; k++)
      @(negedge clock);
    if (cmd_done !== 1'b1)
      fail("request never finished");
  endtask

  always @(negedge clock)
  begin
    if (xfer_start === 1'b1)
      seen_xs = 1'b1;
    if (cmd_done === 1'b1 && notes.size() == 0)
      fail("result with no request");
    else if (cmd_done === 1'b1)
    begin
      n = notes.pop_front();
      cmp_code(cmd_err, n.err);
      cmp_flag(app_accepted, n.app, "app status");
      cmp_flag(seen_xs, n.xs, "transfer start");
      if (n.xs)
        cmp_flag(xfer_dir, n.dir, "direction");
      if (n.err != 3'h1 && n.idx != 6'h00)
        cmp_frame(frame, {2'b01, n.idx, n.arg, crc({2'b01, n.idx, n.arg}), 1'b1});
      if (n.err == 3'h0 && n.idx != 6'h00)
      begin
        cmp_flag(card_status[5], n.app, "status app bit");
        cmp_flag(card_status[19], n.cid, "id lock");
      end
      seen_xs = 1'b0;
    end
  end

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial
  begin
    repeat (100_000) @(posedge clock);
    fail("watchdog expired");
    wrap_up;
  end

  initial
  begin
    {reset, cmd_valid, cmd_app, mute, no_app, seen_xs, cid_sent} = 7'b1000000;
    cmd_index = 6'h00;
    cmd_arg = 32'h0000_0000;
    busy_bits = 16'h0003;
    checks = 0;
    miscompares = 0;
    void'($urandom(32'h44a7_7590));
    card_rca = 16'h0001 | 16'($urandom);
    repeat (6) @(negedge clock);
    reset = 1'b0;
    foreach (rsv[i]) issue(rsv[i], $urandom, 1'b0, 3'h1);
    issue(6'h17, 32'h0001_0000 | $urandom, 1'b0, 3'h1);
    issue(6'h38, $urandom, 1'b0, 3'h1);
    issue(6'h00, 32'h0000_0000, 1'b0, 3'h0);
    issue(6'h07, {card_rca, 16'h0000}, 1'b0, 3'h0);
    cmp_flag(card_selected, 1'b1, "selected");
    issue(6'h10, 32'h0000_0200, 1'b0, 3'h0);
    busy_bits = 16'h00c8;
    issue(6'h38, $urandom, 1'b0, 3'h0);
    issue(6'h38, $urandom, 1'b0, 3'h0);
    busy_bits = 16'h0003;
    issue(6'h17, {16'h0000, 16'($urandom)}, 1'b0, 3'h0);
    foreach (normal[i]) issue(normal[i], $urandom, 1'b0, 3'h0);
    issue(6'h0d, $urandom, 1'b1, 3'h0);
    issue(6'h07, $urandom, 1'b1, 3'h0);
    no_app = 1'b1;
    issue(6'h0d, $urandom, 1'b1, 3'h3);
    no_app = 1'b0;
    mute = 1'b1;
    issue(6'h0d, $urandom, 1'b0, 3'h2);
    mute = 1'b0;
    wrap_up;
  end
endmodule // tb_top

`default_nettype wire
